// [src/ipm_core.v]
`timescale 1ns/1ps
`default_nettype none
`include "ipm_map.vh"
module ipm_core #(
  parameter ACC_BOOT_CYC = (`IPM_ACC_BOOT_NS + `IPM_CLK_PERIOD_NS - 1) / `IPM_CLK_PERIOD_NS,
  parameter GYR_SETTLE_CYC = `IPM_GYR_SETTLE_NS / `IPM_CLK_PERIOD_NS,
  parameter [7:0] GYR_CFG_DEFAULT = 8'h00
) (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire ce_in,
  input wire accel_chip_select_in,
  input wire protocol_select_pin_in,
  input wire acc_soft_reset_in,
  input wire gyr_soft_reset_in,
  input wire acc_pwr_we_in,
  input wire [7:0] acc_pwr_data_in,
  input wire gyr_lpm_we_in,
  input wire [7:0] gyr_lpm_data_in,
  input wire gyr_cfg_we_in,
  input wire [7:0] gyr_cfg_data_in,
  input wire acc_sample_valid_in,
  input wire [`IPM_DATA_W-1:0] acc_x_in,
  input wire [`IPM_DATA_W-1:0] acc_y_in,
  input wire [`IPM_DATA_W-1:0] acc_z_in,
  input wire [`IPM_TEMP_W-1:0] temp_in,
  input wire gyr_sample_valid_in,
  input wire [`IPM_DATA_W-1:0] gyr_x_in,
  input wire [`IPM_DATA_W-1:0] gyr_y_in,
  input wire [`IPM_DATA_W-1:0] gyr_z_in,
  input wire rd_start_in,
  input wire [3:0] rd_addr_in,
  input wire rd_burst_in,
  input wire rd_next_in,
  input wire rd_end_in,
  output reg [7:0] rd_data_out,
  output reg rd_valid_out,
  output reg accel_spi_mode_out,
  output reg gyro_spi_mode_out,
  output reg acc_normal_out,
  output reg temp_enable_out,
  output reg acc_busy_out,
  output reg [1:0] gyr_mode_out,
  output reg gyr_busy_out,
  output reg [7:0] gyr_cfg_out,
  output reg [`IPM_TIME_W-1:0] sensor_time_out
);
  localparam [1:0] GM_NORMAL = 2'b00;
  localparam [1:0] GM_SUSPEND = 2'b01;
  localparam [1:0] GM_DEEP = 2'b10;
  localparam [3:0] IDX_ONE = 4'h1;
  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  wire cs_sync;
  wire ps_sync;
  ipm_sync #(
    .W(2)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .d_in({accel_chip_select_in, protocol_select_pin_in}),
    .q_out({cs_sync, ps_sync})
  );
  reg cs_prev_reg;
  reg [1:0] start_cnt_reg;
  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  reg acc_start_reg;
  reg gyr_start_reg;
  wire acc_busy_w;
  wire gyr_busy_w;
  ipm_timer #(
    .CW(24),
    .CYCLES(ACC_BOOT_CYC[23:0])
  ) u_acc_boot (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .start_in(acc_start_reg),
    .busy_out(acc_busy_w)
  );
  ipm_timer #(
    .CW(24),
    .CYCLES(GYR_SETTLE_CYC[23:0])
  ) u_gyr_settle (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .start_in(gyr_start_reg),
    .busy_out(gyr_busy_w)
  );
  // ---------------------------------------------------------------
  // readout storage
  // ---------------------------------------------------------------
  reg [7:0] live_reg [0:15];
  reg [7:0] hold_reg [0:15];
  reg [7:0] msb_shadow_reg;
  reg [3:0] rd_ptr_reg;
  reg burst_reg;
  reg [19:0] tick_acc_reg;
  reg [7:0] rd_byte_next;
  reg [1:0] gyr_target_next;
  wire acc_pwr_ok;
  wire gyr_lpm_ok;
  assign acc_pwr_ok = (acc_pwr_data_in == `IPM_ACC_PWR_NORMAL) ||
                      (acc_pwr_data_in == `IPM_ACC_PWR_SUSPEND);
  assign gyr_lpm_ok = (gyr_lpm_data_in == `IPM_GYR_LPM_NORMAL) ||
                      (gyr_lpm_data_in == `IPM_GYR_LPM_SUSPEND) ||
                      (gyr_lpm_data_in == `IPM_GYR_LPM_DEEP);
  // high byte of the pair comes from the shadow
  always @* begin
    rd_byte_next = burst_reg ? hold_reg[rd_ptr_reg] : live_reg[rd_ptr_reg];
    if (!burst_reg && rd_ptr_reg[0] && (rd_ptr_reg < `IPM_IDX_TIME_0)) begin
      rd_byte_next = msb_shadow_reg;
    end
    if (!burst_reg && (rd_ptr_reg >= `IPM_IDX_GYR_X_LSB) && !rd_ptr_reg[0]) begin
      rd_byte_next = msb_shadow_reg;
    end
  end
  integer i;
  integer j;
  // target mode of a gyro power write
  always @* begin
    gyr_target_next = GM_NORMAL;
    if (gyr_lpm_data_in == `IPM_GYR_LPM_SUSPEND) begin
      gyr_target_next = GM_SUSPEND;
    end else if (gyr_lpm_data_in == `IPM_GYR_LPM_DEEP) begin
      gyr_target_next = GM_DEEP;
    end
  end
  // ---------------------------------------------------------------
  // interface selection
  // ---------------------------------------------------------------
  // the synchroniser shows its reset level for two edges; a chip select
  // idling high would look like a rising edge, so edges are armed late
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_cnt_reg <= 2'b00;
      cs_prev_reg <= 1'b0;
      accel_spi_mode_out <= 1'b0;
      gyro_spi_mode_out <= 1'b0;
    end else if (ce_in) begin
      cs_prev_reg <= cs_sync;
      if (start_cnt_reg != 2'b11) begin
        start_cnt_reg <= start_cnt_reg + 2'b01;
      end
      // latch select level once pipeline is full
      if (start_cnt_reg == 2'b10) begin
        gyro_spi_mode_out <= ps_sync;
      end
      // sticky switch on first rising cs
      if ((start_cnt_reg == 2'b11) && cs_sync && !cs_prev_reg) begin
        accel_spi_mode_out <= 1'b1;
      end
    end
  end
  // ---------------------------------------------------------------
  // accelerometer power
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_normal_out <= 1'b0;
      temp_enable_out <= 1'b0;
      acc_busy_out <= 1'b1;
      acc_start_reg <= 1'b1;
    end else if (ce_in) begin
      // busy covers the start pulse too
      acc_busy_out <= acc_busy_w || acc_start_reg;
      acc_start_reg <= 1'b0;
      if (acc_soft_reset_in) begin
        acc_normal_out <= 1'b0;
        temp_enable_out <= 1'b0;
        acc_start_reg <= 1'b1;
      end else if (acc_pwr_we_in && acc_pwr_ok) begin
        // one register gates accel and temperature
        acc_normal_out <= (acc_pwr_data_in == `IPM_ACC_PWR_NORMAL);
        temp_enable_out <= (acc_pwr_data_in == `IPM_ACC_PWR_NORMAL);
      end
    end
  end
  // ---------------------------------------------------------------
  // sensor time
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sensor_time_out <= 24'h00_0000;
      tick_acc_reg <= 20'h0_0000;
    end else if (ce_in) begin
      // fractional step keeps the long-run rate exact
      if (({1'b0, tick_acc_reg} + {1'b0, `IPM_TICK_INC}) >= {1'b0, `IPM_TICK_WRAP}) begin
        tick_acc_reg <= tick_acc_reg + `IPM_TICK_INC - `IPM_TICK_WRAP;
        sensor_time_out <= sensor_time_out + 24'h00_0001;
      end else begin
        tick_acc_reg <= tick_acc_reg + `IPM_TICK_INC;
      end
      // soft reset restarts the count
      if (acc_soft_reset_in) begin
        sensor_time_out <= 24'h00_0000;
      end
    end
  end
  // ---------------------------------------------------------------
  // gyroscope power
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gyr_mode_out <= GM_NORMAL;
      gyr_busy_out <= 1'b1;
      gyr_start_reg <= 1'b1;
      gyr_cfg_out <= GYR_CFG_DEFAULT;
    end else if (ce_in) begin
      gyr_busy_out <= gyr_busy_w || gyr_start_reg;
      gyr_start_reg <= 1'b0;
      if (gyr_soft_reset_in) begin
        gyr_mode_out <= GM_NORMAL;
        gyr_cfg_out <= GYR_CFG_DEFAULT;
        gyr_start_reg <= 1'b1;
      end else if (gyr_lpm_we_in && gyr_lpm_ok) begin
        gyr_mode_out <= gyr_target_next;
        if (gyr_target_next == GM_DEEP) begin
          gyr_cfg_out <= GYR_CFG_DEFAULT;
        end
        // settle only on a real change
        if (gyr_target_next != gyr_mode_out) begin
          gyr_start_reg <= 1'b1;
        end
      end else if (gyr_cfg_we_in && (gyr_mode_out != GM_DEEP)) begin
        gyr_cfg_out <= gyr_cfg_data_in;
      end
    end
  end
  // ---------------------------------------------------------------
  // sample capture
  // ---------------------------------------------------------------
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (i = 0; i < 16; i = i + 1) begin
        live_reg[i] <= 8'h00;
      end
    end else if (ce_in) begin
      // pack samples as two's complement bytes
      if (acc_sample_valid_in && acc_normal_out && !acc_busy_out) begin
        live_reg[0] <= acc_x_in[7:0];
        live_reg[1] <= acc_x_in[15:8];
        live_reg[2] <= acc_y_in[7:0];
        live_reg[3] <= acc_y_in[15:8];
        live_reg[4] <= acc_z_in[7:0];
        live_reg[5] <= acc_z_in[15:8];
        live_reg[6] <= temp_in[7:0];
        live_reg[7] <= {{5{temp_in[10]}}, temp_in[10:8]};
      end
      live_reg[8] <= sensor_time_out[7:0];
      live_reg[9] <= sensor_time_out[15:8];
      live_reg[10] <= sensor_time_out[23:16];
      if (gyr_sample_valid_in && (gyr_mode_out == GM_NORMAL)) begin
        live_reg[11] <= gyr_x_in[7:0];
        live_reg[12] <= gyr_x_in[15:8];
        live_reg[13] <= gyr_y_in[7:0];
        live_reg[14] <= gyr_y_in[15:8];
        live_reg[15] <= gyr_z_in[7:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // the snapshot costs a second window of flops, traded for reads
  // that never mix two samples
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      rd_ptr_reg <= 4'h0;
      burst_reg <= 1'b0;
      msb_shadow_reg <= 8'h00;
      for (j = 0; j < 16; j = j + 1) begin
        hold_reg[j] <= 8'h00;
      end
    end else if (ce_in) begin
      rd_valid_out <= 1'b0;
      if (rd_start_in) begin
        rd_ptr_reg <= rd_addr_in;
        burst_reg <= rd_burst_in;
        // snapshot the whole window for a burst
        if (rd_burst_in) begin
          for (j = 0; j < 16; j = j + 1) begin
            hold_reg[j] <= live_reg[j];
          end
        end
      end else if (rd_end_in) begin
        burst_reg <= 1'b0;
      end else if (rd_next_in) begin
        rd_data_out <= rd_byte_next;
        rd_valid_out <= 1'b1;
        // low byte read locks the partner
        if (!burst_reg && rd_ptr_reg < `IPM_IDX_LAST) begin
          msb_shadow_reg <= live_reg[rd_ptr_reg + IDX_ONE];
        end
        if (burst_reg) begin
          rd_ptr_reg <= rd_ptr_reg + IDX_ONE;
        end
      end
    end
  end
endmodule // ipm_core
`default_nettype wire

// [src/ipm_map.vh]
`ifndef IPM_MAP_VH
`define IPM_MAP_VH
// accelerometer power control codes
`define IPM_ACC_PWR_NORMAL 8'h04
`define IPM_ACC_PWR_SUSPEND 8'h00
// gyroscope low-power control codes
`define IPM_GYR_LPM_NORMAL 8'h00
`define IPM_GYR_LPM_SUSPEND 8'h80
`define IPM_GYR_LPM_DEEP 8'h20
// register indices of the readout window
`define IPM_IDX_ACC_X_LSB 4'h0
`define IPM_IDX_TEMP_LSB 4'h6
`define IPM_IDX_TIME_0 4'h8
`define IPM_IDX_GYR_X_LSB 4'hB
`define IPM_IDX_LAST 4'hF
// timing in ns and at a 100 ns clock
`define IPM_CLK_PERIOD_NS 100
`define IPM_ACC_BOOT_NS 1000000
`define IPM_GYR_SETTLE_NS 30000000
`define IPM_TICK_NS_X16 625000
// sensor time accumulator: one clock adds a period, a tick costs 39.0625 us (x16)
`define IPM_TICK_INC 20'h0_0640
`define IPM_TICK_WRAP 20'h9_8968
// field widths
`define IPM_DATA_W 16
`define IPM_TEMP_W 11
`define IPM_TIME_W 24
`endif

// [src/ipm_sync.v]
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin inputs
module ipm_sync #(
  parameter W = 1
) (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire ce_in,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] meta_reg;
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else if (ce_in) begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule // ipm_sync
`default_nettype wire

// [src/ipm_timer.v]
`timescale 1ns/1ps
`default_nettype none
// busy for CYCLES clocks after a start pulse
module ipm_timer #(
  parameter CW = 19,
  parameter [CW-1:0] CYCLES = 1
) (
  input wire ref_clk_in,
  input wire resetn_in,
  input wire ce_in,
  input wire start_in,
  output wire busy_out
);
  reg [CW-1:0] cnt_reg;
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_reg <= {CW{1'b0}};
    end else if (ce_in) begin
      if (start_in) begin
        cnt_reg <= CYCLES;
      end else if (cnt_reg != {CW{1'b0}}) begin
        cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
  assign busy_out = (cnt_reg != {CW{1'b0}});
endmodule // ipm_timer
`default_nettype wire

// [bench/ipm_core_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// power mode checker
// ----------------------------------------
module ipm_core_props #(
  parameter [7:0] GYR_CFG_DEFAULT = 8'h00
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic acc_soft_reset_in,
  input wire logic gyr_soft_reset_in,
  input wire logic acc_pwr_we_in,
  input wire logic [7:0] acc_pwr_data_in,
  input wire logic gyr_lpm_we_in,
  input wire logic [7:0] gyr_lpm_data_in,
  input wire logic accel_spi_mode_out,
  input wire logic acc_normal_out,
  input wire logic temp_enable_out,
  input wire logic acc_busy_out,
  input wire logic [1:0] gyr_mode_out,
  input wire logic [7:0] gyr_cfg_out,
  input wire logic [23:0] sensor_time_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // soft reset outranks a power write taken at the same edge
  wire acc_wr = ce_in && acc_pwr_we_in && !acc_soft_reset_in;
  wire gyr_wr = ce_in && gyr_lpm_we_in && !gyr_soft_reset_in;
  property p_acc_norm; acc_wr && acc_pwr_data_in == 8'h04 |=> acc_normal_out; endproperty
  a_acc_norm: assert property (p_acc_norm) else $error("accel normal missed");
  property p_acc_susp;
    acc_wr && acc_pwr_data_in == 8'h00 |=> !acc_normal_out && !temp_enable_out;
  endproperty
  a_acc_susp: assert property (p_acc_susp) else $error("accel suspend missed");
  property p_acc_keep;
    acc_wr && acc_pwr_data_in != 8'h00 && acc_pwr_data_in != 8'h04 |=> $stable(acc_normal_out);
  endproperty
  a_acc_keep: assert property (p_acc_keep) else $error("accel mode moved");
  property p_gyr_susp; gyr_wr && gyr_lpm_data_in == 8'h80 |=> gyr_mode_out == 2'd1; endproperty
  a_gyr_susp: assert property (p_gyr_susp) else $error("gyro suspend missed");
  property p_gyr_deep;
    gyr_wr && gyr_lpm_data_in == 8'h20 |=> gyr_mode_out == 2'd2 && gyr_cfg_out == GYR_CFG_DEFAULT;
  endproperty
  a_gyr_deep: assert property (p_gyr_deep) else $error("gyro deep missed");
  property p_gyr_wake; gyr_wr && gyr_lpm_data_in == 8'h00 |=> gyr_mode_out == 2'd0; endproperty
  a_gyr_wake: assert property (p_gyr_wake) else $error("gyro wake missed");
  property p_spi_keep; !$fell(accel_spi_mode_out); endproperty
  a_spi_keep: assert property (p_spi_keep) else $error("accel spi lost");
  property p_acc_boot; ce_in && acc_soft_reset_in |-> ##2 acc_busy_out[*3]; endproperty
  a_acc_boot: assert property (p_acc_boot) else $error("accel boot wait missing");
  property p_time;
    !acc_soft_reset_in && !$past(acc_soft_reset_in) |=> sensor_time_out == $past(sensor_time_out)
      || sensor_time_out == $past(sensor_time_out) + 24'h00_0001;
  endproperty
  a_time: assert property (p_time) else $error("sensor time jumped");
endmodule // ipm_core_props
bind ipm_core ipm_core_props #(.GYR_CFG_DEFAULT(GYR_CFG_DEFAULT)) i_props (.*);
`default_nettype wire

// [bench/ipm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host side
// ----------------------------------------
module ipm_host_model (
  input wire logic go_in,
  output var logic accel_chip_select_out
);
  // low until the host sets its pin up; idle high after the first frame
  initial accel_chip_select_out = 1'b0;
  always @(posedge go_in) begin
    accel_chip_select_out = 1'b0;
    repeat (16) #400;
    accel_chip_select_out = 1'b1;
  end
endmodule // ipm_host_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module testbench;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic sv = 1'b0;
  logic [1:0] srst = 2'h0;
  logic [2:0] we = 3'h0;
  logic [7:0] wd = 8'h00;
  logic [15:0] s = 16'h0000;
  logic [3:0] rq = 4'h0;
  logic [3:0] ad = 4'h0;
  logic [7:0] rdo, gcfg;
  logic rv, aspi, gspi, an, te, ab, gb;
  logic [1:0] gm;
  logic [23:0] tm, t0;
  logic [7:0] got [0:3];
  wire cs;
  int failures = 0;
  int checks = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  ipm_host_model i_host (.go_in(go), .accel_chip_select_out(cs));
  ipm_core #(.ACC_BOOT_CYC(20), .GYR_SETTLE_CYC(50)) i_dut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(ce),
    .accel_chip_select_in(cs), .protocol_select_pin_in(1'b1),
    .acc_soft_reset_in(srst[0]), .gyr_soft_reset_in(srst[1]), .acc_pwr_we_in(we[0]),
    .acc_pwr_data_in(wd), .gyr_lpm_we_in(we[1]), .gyr_lpm_data_in(wd), .gyr_cfg_we_in(we[2]),
    .gyr_cfg_data_in(wd), .acc_sample_valid_in(sv), .acc_x_in(s), .acc_y_in(s), .acc_z_in(s),
    .temp_in(s[10:0]), .gyr_sample_valid_in(sv), .gyr_x_in(s), .gyr_y_in(s), .gyr_z_in(s),
    .rd_start_in(rq[0]), .rd_addr_in(ad), .rd_burst_in(rq[3]), .rd_next_in(rq[1]),
    .rd_end_in(rq[2]), .rd_data_out(rdo), .rd_valid_out(rv), .accel_spi_mode_out(aspi),
    .gyro_spi_mode_out(gspi), .acc_normal_out(an), .temp_enable_out(te), .acc_busy_out(ab),
    .gyr_mode_out(gm), .gyr_busy_out(gb), .gyr_cfg_out(gcfg), .sensor_time_out(tm)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    we[k] = 1'b1;
    wd = d;
    tick(1);
    we = 3'h0;
    tick(1);
  endtask
  task automatic smp(input logic [15:0] v);
    s = v;
    sv = 1'b1;
    tick(1);
    sv = 1'b0;
  endtask
  task automatic idle(input int k);
    int i;
    for (i = 0; i < 400 && (k ? gb : ab) !== 1'b0; i++) tick(1);
    chk("busy_drop", 0, k ? gb : ab);
    if ((k ? gb : ab) !== 1'b0)
      results;
  endtask
  task automatic rd(input logic [3:0] a, input logic b, input int n);
    int i, j;
    ad = a;
    rq = {b, 3'b001};
    tick(1);
    rq = {b, 3'b000};
    for (i = 0; i < n; i++) begin
      // a fresh sample mid-burst must not leak into the frozen window
      if (i == 1)
        smp(~s);
      rq[1] = 1'b1;
      tick(1);
      rq[1] = 1'b0;
      for (j = 0; j < 4 && rv !== 1'b1; j++) tick(1);
      chk("rd_valid", 1, rv);
      if (rv !== 1'b1)
        results;
      got[i] = rdo;
    end
    rq = {b, 3'b100};
    tick(1);
    rq = 4'h0;
  endtask
  initial begin
    int i;
    tick(5);
    resetn_in = 1'b1;
    chk("acc_normal", 0, an);
    chk("gyr_mode", 0, gm);
    chk("accel_spi", 0, aspi);
    chk("acc_busy", 1, ab);
    idle(0);
    chk("gyro_spi", 1, gspi);
    go = 1'b1;
    for (i = 0; i < 200 && aspi !== 1'b1; i++) tick(1);
    chk("accel_spi", 1, aspi);
    if (aspi !== 1'b1)
      results;
    wr(2, 8'h5A);
    wr(0, 8'h33);
    chk("acc_normal", 0, an);
    wr(0, 8'h04);
    chk("acc_normal", 1, an);
    chk("temp_en", 1, te);
    tick(4500);
    idle(0);
    smp(16'h1234);
    rd(0, 0, 1);
    smp(16'hABCD);
    rd(1, 0, 1);
    chk("acc_x_msb", 8'h12, got[0]);
    rd(0, 1, 3);
    chk("burst0", 8'hCD, got[0]);
    chk("burst1", 8'hAB, got[1]);
    chk("burst2", 8'hCD, got[2]);
    smp(16'h5432);
    rd(6, 0, 1);
    rd(7, 0, 1);
    chk("temp_msb", 8'hFC, got[0]);
    wr(1, 8'h80);
    chk("gyr_mode", 1, gm);
    chk("gyr_cfg", 8'h5A, gcfg);
    smp(16'h7777);
    rd(11, 0, 1);
    chk("gyr_x_lsb", 8'h32, got[0]);
    idle(1);
    wr(1, 8'h20);
    chk("gyr_mode", 2, gm);
    wr(2, 8'h66);
    chk("gyr_cfg", 8'h00, gcfg);
    wr(1, 8'h00);
    chk("gyr_mode", 0, gm);
    wr(2, 8'h5A);
    chk("gyr_cfg", 8'h5A, gcfg);
    wr(1, 8'h80);
    srst = 2'b10;
    tick(1);
    srst = 2'b00;
    tick(1);
    chk("gyr_mode", 0, gm);
    ce = 1'b0;
    t0 = tm;
    tick(800);
    chk("ce_freeze", t0, tm);
    ce = 1'b1;
    t0 = tm;
    tick(782);
    chk("time_step", 1, (tm - t0) >= 2 && (tm - t0) <= 3);
    wr(0, 8'h00);
    chk("temp_en", 0, te);
    srst = 2'b01;
    tick(1);
    srst = 2'b00;
    tick(2);
    chk("acc_busy", 1, ab);
    resetn_in = 1'b0;
    tick(2);
    chk("accel_spi", 0, aspi);
    resetn_in = 1'b1;
    tick(4);
    chk("gyro_spi", 1, gspi);
    chk("accel_spi", 0, aspi);
    results;
  end
endmodule // testbench
`default_nettype wire
